// ==== rtl/bio_defines.svh ====
// Register offsets, field positions, reset values for the I/O port block.
// Assumes inclusion from the top module, the checker and the bench.
// Function
// (R01) Direction bit one tristates the pin driver; pin is an input.
// (R02) Direction bit zero drives the pin from its output latch bit.
// (R03) Latch register reads and writes the latch itself, not the pins.
// (R04) All direction registers reset to all ones on every reset.
// (R05) Data and latch contents undefined at power-on, kept on other resets.
// (R06) Port D plain I/O only while external bus disable bit is set.
// (R07) With external bus active, port D carries address/data low byte.
// (R08) Slave port mode makes port D an 8-bit host data port.
// (R09) Schmitt buffering in plain I/O, TTL in bus or slave port mode.
// (R10) External program memory modes turn all port E into high byte; code does so on the large package only.
// (R11) Internal-only mode with slave mode: port E 2..0 are strobes.
// (R12) Software sets port E direction 2..0 and digital inputs first.
// (R13) Internal-only mode: port E bit 7 is capture pin 2 if select clear.
// (R14) Large package, extended internal mode: port E defaults to bus.
// (R15) Slave control holds flags in bits 7..4, low bits read zero.
// (R16) Strobes active low: read, write and select from the host.
// (R17) Function overrides never write into the direction register.
// (R18) Data register reads pins; writes update the output latch.
`ifndef BIO_DEFINES_SVH
`define BIO_DEFINES_SVH
`define BIO_OFS_C_PIN    12'h000
`define BIO_OFS_C_LAT    12'h004
`define BIO_OFS_C_DIR    12'h008
`define BIO_OFS_D_PIN    12'h00C
`define BIO_OFS_D_LAT    12'h010
`define BIO_OFS_D_DIR    12'h014
`define BIO_OFS_E_PIN    12'h018
`define BIO_OFS_E_LAT    12'h01C
`define BIO_OFS_E_DIR    12'h020
`define BIO_OFS_SPCTL    12'h024
`define BIO_OFS_MEMCTL   12'h028
`define BIO_OFS_STATUS   12'h02C
`define BIO_DIR_RST      8'hFF
`define BIO_LAT_RST      8'h00
`define BIO_SPCTL_RST    4'h0
`define BIO_MEMCTL_RST   8'h00
`define BIO_MEMCTL_MASK  8'hBF
`define BIO_EXTERNAL_BUS_DISABLE_BIT    7
`define BIO_IBF_BIT      7
`define BIO_OBF_BIT      6
`define BIO_INPUT_BUFFER_OVERFLOW_BIT     5
`define BIO_MODE_BIT     4
`endif

// ==== rtl/bio_pkg.sv ====
// Types shared by the I/O port block.
// Assumes the defines header is compiled alongside.
package bio_pkg;
    // Program memory modes, set by configuration outside the block
    typedef enum logic [1:0] {
        BIO_MM_INTERNAL,
        BIO_MM_EXT_INTERNAL,
        BIO_MM_MICROPROC
    } bio_mem_mode_t;

    // One 8-bit port at the pins
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } bio_pin_drv_t;

    // External bus driving request from the memory interface
    typedef struct packed {
        logic [15:0] ad_out;
        logic        ad_oe;
    } bio_ext_bus_t;
endpackage

// ==== rtl/bio_ports.sv ====
// Three bidirectional 8-bit ports with bus and slave port sharing.
// Assumes AHB-Lite single word transfers and asynchronous pin inputs.
// Undefined power-on latch contents are modelled as zero.
`include "bio_defines.svh"
module bio_ports
    import bio_pkg::*;
(
    input  wire logic          core_clk,
    input  wire logic          arst_n,
    input  wire logic          clk_en,
    input  wire logic          por_n,
    input  wire bio_mem_mode_t mem_mode,
    input  wire logic          large_pkg,
    input  wire logic          capture2_pin_select,
    input  wire logic          ccp2_out,
    input  wire logic          ccp2_oe,
    input  wire bio_ext_bus_t  ext_bus,
    output      logic [15:0]   ext_bus_in,
    output      logic          ccp2_in,
    input  wire logic          hsel,
    input  wire logic [11:0]   haddr,
    input  wire logic [1:0]    htrans,
    input  wire logic          hwrite,
    input  wire logic [2:0]    hsize,
    input  wire logic [31:0]   hwdata,
    input  wire logic          hready,
    output      logic [31:0]   hrdata,
    output      logic          hreadyout,
    output      logic          hresp,
    input  wire logic [7:0]    port_c_in,
    input  wire logic [7:0]    port_d_in,
    input  wire logic [7:0]    port_e_in,
    output      bio_pin_drv_t  port_c_drv,
    output      bio_pin_drv_t  port_d_drv,
    output      bio_pin_drv_t  port_e_drv,
    output      logic          schmitt_sel_d,
    output      logic          schmitt_sel_e
);
    // Reset release chain
    logic        rst_s1_q;
    logic        rst_n_q;

    // Pin synchroniser stages
    logic [7:0]  c_s1_q;
    logic [7:0]  d_s1_q;
    logic [7:0]  e_s1_q;
    logic [7:0]  c_pin_q;
    logic [7:0]  d_pin_q;
    logic [7:0]  e_pin_q;

    // Software visible port state
    logic [7:0]  c_lat_q;
    logic [7:0]  d_lat_q;
    logic [7:0]  e_lat_q;
    logic [7:0]  c_dir_q;
    logic [7:0]  d_dir_q;
    logic [7:0]  e_dir_q;
    logic [3:0]  spctl_q;
    logic [7:0]  memctl_q;

    // Slave port data, one byte each way
    logic [7:0]  host_in_q;
    logic [7:0]  host_out_q;

    // Host strobes, active low, and their history
    logic        cs_n;
    logic        rd_n;
    logic        wr_n;
    logic        wr_n_prev_q;
    logic        rd_n_prev_q;

    // Register bus data phase
    logic        ap_valid;
    logic        wr_pend_q;
    logic [11:0] addr_q;
    logic [7:0]  wdata;

    // Pin ownership decode
    logic        bus_active;
    logic        ad_high_bus;
    logic        sp_active;
    logic        ccp_alt;

    // Reset asserts at once; release is retimed through two flops
    // so every flop on rst_n_q leaves reset on the same edge
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_s1_q <= 1'b0;
            rst_n_q  <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q  <= rst_s1_q;
        end
    end

    // Pin synchronisers; first stage feeds only the second
    // Strobes and data share one delay, so they stay in step
    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            c_s1_q  <= 8'h00;
            d_s1_q  <= 8'h00;
            e_s1_q  <= 8'h00;
            c_pin_q <= 8'h00;
            d_pin_q <= 8'h00;
            e_pin_q <= 8'h00;
        end else if (clk_en) begin
            c_s1_q  <= port_c_in;
            d_s1_q  <= port_d_in;
            e_s1_q  <= port_e_in;
            c_pin_q <= c_s1_q;
            d_pin_q <= d_s1_q;
            e_pin_q <= e_s1_q;
        end
    end

    // Mode decode; port E bus on large package in extended mode [R14]
    // Memctl resets to zero, so in external modes the bus owns the pins after reset
    assign bus_active  = !memctl_q[`BIO_EXTERNAL_BUS_DISABLE_BIT]
                         && mem_mode != BIO_MM_INTERNAL;           // [R06]
    assign ad_high_bus = bus_active && large_pkg;                  // [R10]
    assign sp_active   = spctl_q[`BIO_MODE_BIT - 4]
                         && mem_mode == BIO_MM_INTERNAL;           // [R08]
    assign ccp_alt     = mem_mode == BIO_MM_INTERNAL
                         && !capture2_pin_select;                  // [R13]
    assign cs_n = e_pin_q[2];                                      // [R16]
    assign wr_n = e_pin_q[1];
    assign rd_n = e_pin_q[0];
    assign ext_bus_in = {e_pin_q, d_pin_q};
    assign ccp2_in    = e_pin_q[7];
    assign schmitt_sel_d = !(bus_active || sp_active);             // [R09]
    assign schmitt_sel_e = !(ad_high_bus || sp_active);

    // Port C pins: plain latch and direction
    // No bus or slave port function on this port
    assign port_c_drv.out = c_lat_q;                               // [R02]
    assign port_c_drv.oe  = ~c_dir_q;                              // [R01]

    // Port D pins: bus, slave port or plain I/O; direction left alone
    // Bus wins over slave port; the two modes never overlap
    always_comb begin
        if (bus_active) begin
            port_d_drv.out = ext_bus.ad_out[7:0];                  // [R07]
            port_d_drv.oe  = {8{ext_bus.ad_oe}};                   // [R17]
        end else if (sp_active) begin
            port_d_drv.out = host_out_q;
            port_d_drv.oe  = {8{!cs_n && !rd_n}};                  // [R16]
        end else begin
            port_d_drv.out = d_lat_q;
            port_d_drv.oe  = ~d_dir_q;                             // [R01]
        end
    end

    // Port E pins: bus high byte, strobe inputs, capture alternate
    // Strobe pins are inputs in slave mode whatever the direction
    // register holds; software still reads its own value back
    always_comb begin
        port_e_drv.out = e_lat_q;
        port_e_drv.oe  = ~e_dir_q;
        if (ad_high_bus) begin
            port_e_drv.out = ext_bus.ad_out[15:8];                 // [R10]
            port_e_drv.oe  = {8{ext_bus.ad_oe}};
        end else begin
            if (sp_active) begin
                port_e_drv.oe[2:0] = 3'h0;                         // [R11]
            end
            if (ccp_alt) begin
                port_e_drv.out[7] = ccp2_out;                      // [R13]
                port_e_drv.oe[7]  = ccp2_oe;
            end
        end
    end

    // AHB address phase capture; writes land in the data phase
    // Zero wait states; only byte lane 0 carries register data
    assign ap_valid  = hsel && htrans[1] && hready;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign wdata     = hwdata[7:0];

    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            wr_pend_q <= 1'b0;
            addr_q    <= 12'h000;
        end else if (clk_en) begin
            wr_pend_q <= ap_valid && hwrite;
            if (ap_valid) begin
                addr_q <= haddr;
            end
        end
    end

    // Read data registered at the address phase
    // Unmapped offsets and the upper lanes read zero
    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            hrdata <= 32'h0000_0000;
        end else if (clk_en && ap_valid && !hwrite) begin
            hrdata <= 32'h0000_0000;
            if (haddr == `BIO_OFS_C_PIN) begin
                hrdata[7:0] <= c_pin_q;                            // [R18]
            end else if (haddr == `BIO_OFS_C_LAT) begin
                hrdata[7:0] <= c_lat_q;                            // [R03]
            end else if (haddr == `BIO_OFS_C_DIR) begin
                hrdata[7:0] <= c_dir_q;
            end else if (haddr == `BIO_OFS_D_PIN) begin
                hrdata[7:0] <= d_pin_q;
            end else if (haddr == `BIO_OFS_D_LAT) begin
                hrdata[7:0] <= d_lat_q;
            end else if (haddr == `BIO_OFS_D_DIR) begin
                hrdata[7:0] <= d_dir_q;
            end else if (haddr == `BIO_OFS_E_PIN) begin
                hrdata[7:0] <= e_pin_q;
            end else if (haddr == `BIO_OFS_E_LAT) begin
                hrdata[7:0] <= e_lat_q;
            end else if (haddr == `BIO_OFS_E_DIR) begin
                hrdata[7:0] <= e_dir_q;
            end else if (haddr == `BIO_OFS_SPCTL) begin
                hrdata[7:0] <= {spctl_q, 4'h0};                    // [R15]
            end else if (haddr == `BIO_OFS_MEMCTL) begin
                hrdata[7:0] <= memctl_q;
            end else if (haddr == `BIO_OFS_STATUS) begin
                hrdata[7:0] <= host_in_q;
            end
        end
    end

    // Direction registers; only a software write changes them
    // Bus, host and capture overrides act on the drivers only
    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            c_dir_q <= `BIO_DIR_RST;                               // [R04]
            d_dir_q <= `BIO_DIR_RST;
            e_dir_q <= `BIO_DIR_RST;
        end else if (clk_en && wr_pend_q) begin
            if (addr_q == `BIO_OFS_C_DIR) begin
                c_dir_q <= wdata;                                  // [R17]
            end else if (addr_q == `BIO_OFS_D_DIR) begin
                d_dir_q <= wdata;
            end else if (addr_q == `BIO_OFS_E_DIR) begin
                e_dir_q <= wdata;
            end
        end
    end

    // Latches survive warm resets; cleared only by power-on reset
    // Pin offset writes land here too; read-modify-write on the pin
    // offset copies input levels in, so use the latch offset
    always_ff @(posedge core_clk or negedge por_n) begin
        if (!por_n) begin
            c_lat_q <= `BIO_LAT_RST;                               // [R05]
            d_lat_q <= `BIO_LAT_RST;
            e_lat_q <= `BIO_LAT_RST;
        end else if (clk_en && wr_pend_q) begin
            if (addr_q == `BIO_OFS_C_PIN || addr_q == `BIO_OFS_C_LAT) begin
                c_lat_q <= wdata;                                  // [R18]
            end else if (addr_q == `BIO_OFS_D_PIN
                         || addr_q == `BIO_OFS_D_LAT) begin
                d_lat_q <= wdata;                                  // [R03]
            end else if (addr_q == `BIO_OFS_E_PIN
                         || addr_q == `BIO_OFS_E_LAT) begin
                e_lat_q <= wdata;
            end
        end
    end

    // Memory interface control; bit 6 unimplemented
    // Wait and write mode bits are stored only; they steer nothing
    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            memctl_q <= `BIO_MEMCTL_RST;
        end else if (clk_en && wr_pend_q && addr_q == `BIO_OFS_MEMCTL) begin
            memctl_q <= wdata & `BIO_MEMCTL_MASK;                  // [R06]
        end
    end

    // Strobe edge history for the host handshake
    // Tracked outside slave mode too, so enabling it with idle
    // strobes raises no false edge
    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            wr_n_prev_q <= 1'b1;
            rd_n_prev_q <= 1'b1;
        end else if (clk_en) begin
            wr_n_prev_q <= wr_n || cs_n;
            rd_n_prev_q <= rd_n || cs_n;
        end
    end

    // Slave port flags; hardware set wins over software clear
    // Overflow marks a host write onto a full buffer; data replaced
    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            spctl_q    <= `BIO_SPCTL_RST;                          // [R15]
            host_in_q  <= 8'h00;
            host_out_q <= 8'h00;
        end else if (clk_en) begin
            // Software writes the mode bit and can only clear overflow
            if (wr_pend_q && addr_q == `BIO_OFS_SPCTL) begin
                spctl_q[`BIO_MODE_BIT - 4] <= wdata[`BIO_MODE_BIT];
                if (!wdata[`BIO_INPUT_BUFFER_OVERFLOW_BIT]) begin
                    spctl_q[`BIO_INPUT_BUFFER_OVERFLOW_BIT - 4] <= 1'b0;
                end
            end
            // Host read release clears first, so a load in the
            // same cycle still leaves output full set
            if (sp_active && (rd_n || cs_n) && !rd_n_prev_q) begin
                spctl_q[`BIO_OBF_BIT - 4] <= 1'b0;
            end
            if (wr_pend_q && addr_q == `BIO_OFS_D_PIN) begin
                host_out_q <= wdata;
                spctl_q[`BIO_OBF_BIT - 4] <= 1'b1;
            end
            // Cleared on the read address phase, with the data capture
            if (ap_valid && !hwrite && haddr == `BIO_OFS_STATUS) begin
                spctl_q[`BIO_IBF_BIT - 4] <= 1'b0;
            end
            // Host write completes at strobe release [R16]
            if (sp_active && (wr_n || cs_n) && !wr_n_prev_q) begin
                host_in_q <= d_pin_q;                              // [R08]
                spctl_q[`BIO_IBF_BIT - 4] <= 1'b1;
                if (spctl_q[`BIO_IBF_BIT - 4]) begin
                    spctl_q[`BIO_INPUT_BUFFER_OVERFLOW_BIT - 4] <= 1'b1;
                end
            end
        end
    end
endmodule

// ==== dv/bio_ports_properties.sv ====
// Checker for the I/O port block, bound to its top module.
// Assumes one clock domain and AHB-Lite single word transfers.
`include "bio_defines.svh"
module bio_ports_properties
    import bio_pkg::*;
(
    input wire logic          core_clk,
    input wire logic          arst_n,
    input wire logic          clk_en,
    input wire bio_mem_mode_t mem_mode,
    input wire bio_ext_bus_t  ext_bus,
    input wire logic          large_pkg,
    input wire logic          hsel,
    input wire logic [11:0]   haddr,
    input wire logic [1:0]    htrans,
    input wire logic          hwrite,
    input wire logic [31:0]   hwdata,
    input wire logic          hready,
    input wire logic [31:0]   hrdata,
    input wire logic [7:0]    port_e_in,
    input wire bio_pin_drv_t  port_c_drv,
    input wire bio_pin_drv_t  port_d_drv,
    input wire bio_pin_drv_t  port_e_drv,
    input wire logic          schmitt_sel_d
);
    logic        aw_q, ar_q, ebd_q, mode_q, bus_act, sp_act;
    logic [11:0] ad_q;
    // Data phase tracker
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            {aw_q, ar_q, ad_q} <= '0;
        end else if (clk_en) begin
            aw_q <= hsel & htrans[1] & hready & hwrite;
            ar_q <= hsel & htrans[1] & hready & !hwrite;
            ad_q <= haddr;
        end
    end
    // Mirror of the bits that decide who owns the pins
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            {ebd_q, mode_q} <= 2'h0;
        end else if (clk_en && aw_q && ad_q == `BIO_OFS_MEMCTL) begin
            ebd_q <= hwdata[`BIO_EXTERNAL_BUS_DISABLE_BIT];
        end else if (clk_en && aw_q && ad_q == `BIO_OFS_SPCTL) begin
            mode_q <= hwdata[`BIO_MODE_BIT];
        end
    end
    assign bus_act = !ebd_q && mem_mode != BIO_MM_INTERNAL;
    assign sp_act  = mode_q && mem_mode == BIO_MM_INTERNAL;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);
    sequence s_wr(logic [11:0] a);
        clk_en && aw_q && ad_q == a;
    endsequence
    // Host read strobe held long enough to pass the synchroniser
    sequence s_host_rd;
        (sp_act && port_e_in[2:0] == 3'h2) [*4];
    endsequence
    property p_c_dir;
        s_wr(`BIO_OFS_C_DIR) |=> port_c_drv.oe == ~$past(hwdata[7:0]);
    endproperty
    a_c_dir: assert property (p_c_dir) else $error("C enables");
    property p_c_lat;
        clk_en && aw_q &&
            (ad_q == `BIO_OFS_C_LAT || ad_q == `BIO_OFS_C_PIN) |=>
            (port_c_drv.out & port_c_drv.oe) ==
            ($past(hwdata[7:0]) & port_c_drv.oe);
    endproperty
    a_c_lat: assert property (p_c_lat) else $error("C out");
    property p_rst;
        disable iff (1'h0) !arst_n |-> port_c_drv.oe == 8'h00;
    endproperty
    a_rst: assert property (p_rst) else $error("C driven in reset");
    property p_d_bus;
        bus_act && ext_bus.ad_oe |-> port_d_drv.oe == 8'hFF &&
            port_d_drv.out == ext_bus.ad_out[7:0];
    endproperty
    a_d_bus: assert property (p_d_bus) else $error("D bus");
    property p_e_bus;
        bus_act && large_pkg && ext_bus.ad_oe |->
            port_e_drv.out == ext_bus.ad_out[15:8];
    endproperty
    a_e_bus: assert property (p_e_bus) else $error("E bus");
    property p_schmitt;
        $stable(mem_mode) |-> schmitt_sel_d == !(bus_act || sp_act);
    endproperty
    a_schmitt: assert property (p_schmitt) else $error("buffer");
    property p_spc;
        ar_q && ad_q == `BIO_OFS_SPCTL |-> hrdata[3:0] == 4'h0 &&
            hrdata[31:8] == 24'h0;
    endproperty
    a_spc: assert property (p_spc) else $error("ctl low bits");
    property p_host;
        s_host_rd |-> port_d_drv.oe == 8'hFF;
    endproperty
    a_host: assert property (p_host) else $error("host read");
endmodule
bind bio_ports bio_ports_properties u_props (
    .core_clk, .arst_n, .clk_en, .mem_mode, .ext_bus, .large_pkg, .hsel,
    .haddr,
    .htrans, .hwrite, .hwdata, .hready, .hrdata, .port_e_in,
    .port_c_drv, .port_d_drv, .port_e_drv, .schmitt_sel_d
);

// ==== dv/bio_host_model.sv ====
// Far-side model: resolves the pins and plays the slave port host.
// Assumes strobes on port E bits 2..0 and host data on port D.
module bio_host_model
    import bio_pkg::*;
(
    input  wire logic         core_clk,
    input  wire bio_pin_drv_t port_c_drv,
    input  wire bio_pin_drv_t port_d_drv,
    input  wire bio_pin_drv_t port_e_drv,
    input  wire logic [23:0]  ext_val,
    input  wire logic [23:0]  ext_en,
    output      logic [7:0]   port_c_in,
    output      logic [7:0]   port_d_in,
    output      logic [7:0]   port_e_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0]  hd = 8'h00;
    logic        hd_en = 1'h0, he_en = 1'h0;
    logic [2:0]  he = 3'h7;
    logic [23:0] flt_q = 24'h0, v, e, oe;
    // Undriven pins flip each cycle, so no stale level passes
    always @(posedge core_clk) flt_q <= ~{port_e_in, port_d_in, port_c_in};
    always_comb begin
        v = {ext_val[23:19], he_en ? he : ext_val[18:16],
             hd_en ? hd : ext_val[15:8], ext_val[7:0]};
        e = ext_en | {5'h0, {3{he_en}}, {8{hd_en}}, 8'h0};
        oe = {port_e_drv.oe, port_d_drv.oe, port_c_drv.oe};
        {port_e_in, port_d_in, port_c_in} = (~oe & e & v) | (~oe & ~e & flt_q)
            | (oe & {port_e_drv.out, port_d_drv.out, port_c_drv.out});
    end
    // Write: select and write low, data kept past the rising edge
    task automatic host_write(input logic [7:0] b);
        hd <= b;
        hd_en <= 1'h1;
        he_en <= 1'h1;
        he <= 3'h1;
        repeat (4) @(posedge core_clk);
        he <= 3'h7;
        repeat (4) @(posedge core_clk);
        hd_en <= 1'h0;
        @(posedge core_clk);
    endtask
    // Read: data taken while select and read are still low
    task automatic host_read(output logic [7:0] b);
        he_en <= 1'h1;
        he <= 3'h2;
        repeat (5) @(posedge core_clk);
        b = port_d_in;
        he <= 3'h7;
        repeat (4) @(posedge core_clk);
    endtask
endmodule

// ==== dv/bio_ports_bench.sv ====
// Self-checking bench for the I/O port block with the pin model.
// Assumes zero wait states and the offsets of the defines header.
`include "bio_defines.svh"
module bio_ports_bench
    import bio_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic          core_clk = 1'h0, arst_n = 1'h1, por_n = 1'h1;
    bio_mem_mode_t mem_mode = BIO_MM_MICROPROC;
    bio_ext_bus_t  ext_bus = '0;
    logic          cap_sel = 1'h1, ccp_o = 1'h0, ccp_oe = 1'h0, sch_d, sch_e;
    logic          ce = 1'h1, lpk = 1'h1;
    logic          hsel = 1'h0, hwrite = 1'h0, hreadyout, hresp, ccp2_in;
    logic [1:0]    htrans = 2'h0;
    logic [11:0]   haddr = '0;
    logic [31:0]   hwdata = '0, hrdata, rd;
    logic [23:0]   ext_val = '0, ext_en = 24'hFFFFFF;
    logic [15:0]   ext_bus_in;
    logic [7:0]    pc_in, pd_in, pe_in, b, lat[3], dir[3], memctl, spctl;
    bio_pin_drv_t  pc_drv, pd_drv, pe_drv;
    int            err_count = 0, total_checks = 0, cyc = 0;
    always #5 core_clk = ~core_clk;
    bio_ports bio_ports_inst (
        .core_clk, .arst_n, .clk_en(ce), .por_n, .mem_mode,
        .large_pkg(lpk), .capture2_pin_select(cap_sel), .ccp2_out(ccp_o),
        .ccp2_oe(ccp_oe), .ext_bus, .ext_bus_in, .ccp2_in, .hsel, .haddr,
        .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
        .hrdata, .hreadyout, .hresp, .port_c_in(pc_in), .port_d_in(pd_in),
        .port_e_in(pe_in), .port_c_drv(pc_drv), .port_d_drv(pd_drv),
        .port_e_drv(pe_drv), .schmitt_sel_d(sch_d), .schmitt_sel_e(sch_e)
    );
    bio_host_model bio_host_model_inst (
        .core_clk, .port_c_drv(pc_drv), .port_d_drv(pd_drv),
        .port_e_drv(pe_drv), .ext_val, .ext_en, .port_c_in(pc_in),
        .port_d_in(pd_in), .port_e_in(pe_in)
    );
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Hang guard, far above the several hundred cycles needed
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    // Single transfer, entered just after an edge; waits on hready
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d);
        {hsel, htrans, haddr, hwrite} <= {1'h1, 2'h2, a, w};
        @(posedge core_clk);
        while (hreadyout !== 1'h1) @(posedge core_clk);
        {hsel, htrans, hwdata} <= {1'h0, 2'h0, d};
        @(posedge core_clk);
        while (hreadyout !== 1'h1) @(posedge core_clk);
        rd = hrdata;
    endtask
    task automatic rchk(input logic [11:0] a, input logic [7:0] exp);
        xfer(1'h0, a, 32'h0);
        chk(rd, {24'h0, exp});
    endtask
    // Write through the bus and into the reference model
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        xfer(1'h1, a, {24'h0, d});
        if (a == `BIO_OFS_SPCTL)
            spctl = (spctl & 8'hC0) | (d & 8'h10) | (spctl & d & 8'h20);
        else if (a == `BIO_OFS_MEMCTL) memctl = d & `BIO_MEMCTL_MASK;
        else if (a % 12 == 8) dir[a / 12] = d;
        else lat[a / 12] = d;
        if (a == `BIO_OFS_D_PIN) spctl |= 8'h40;
    endtask
    task automatic do_reset(input logic p);
        {arst_n, por_n} <= {1'h0, !p};
        repeat (8) @(posedge core_clk);
        {arst_n, por_n} <= 2'h3;
        repeat (3) @(posedge core_clk);
        {dir[0], dir[1], dir[2], memctl, spctl} = {24'hFFFFFF, 16'h0};
        if (p) {lat[0], lat[1], lat[2]} = 24'h0;
    endtask
    initial begin
        void'($urandom(88230));
        @(posedge core_clk);
        do_reset(1'h1);
        rchk(12'h100, 8'h00);
        for (int k = 0; k < 3; k++) rchk(12'(12 * k + 8), 8'hFF);
        rchk(`BIO_OFS_SPCTL, 8'h00);
        $display("test reset done");
        wr(`BIO_OFS_MEMCTL, 8'h80);
        repeat (20) begin
            ext_val <= 24'($urandom);
            for (int k = 0; k < 3; k++) begin
                wr(12'(12 * k + 8), 8'($urandom));
                wr(12'(12 * k + $urandom % 2 * 4), 8'($urandom));
            end
            repeat (3) @(posedge core_clk);
            for (int k = 0; k < 3; k++) begin
                rchk(12'(12 * k), (lat[k] & ~dir[k]) |
                     (ext_val[8 * k +: 8] & dir[k]));
                rchk(12'(12 * k + 4), lat[k]);
            end
        end
        $display("test plain io done");
        do_reset(1'h0);
        for (int k = 0; k < 3; k++) rchk(12'(12 * k + 4), lat[k]);
        // Frozen clock enable: the write must not land
        ce <= 1'h0;
        xfer(1'h1, `BIO_OFS_C_LAT, {24'h0, ~lat[0]});
        ce <= 1'h1;
        rchk(`BIO_OFS_C_LAT, lat[0]);
        $display("test reset keep done");
        wr(`BIO_OFS_D_DIR, 8'h5A);
        mem_mode <= BIO_MM_EXT_INTERNAL;
        ext_bus <= {16'($urandom), 1'h1};
        repeat (2) @(posedge core_clk);
        chk({pe_drv.out, pd_drv.out}, ext_bus.ad_out);
        chk({sch_d, sch_e}, 2'h0);
        lpk <= 1'h0;
        @(posedge core_clk);
        chk({sch_e, pe_drv.oe}, 9'h100);
        lpk <= 1'h1;
        rchk(`BIO_OFS_D_DIR, 8'h5A);
        {ext_bus, ext_val} <= {17'h0, 24'($urandom)};
        repeat (3) @(posedge core_clk);
        chk(ext_bus_in, ext_val[23:8]);
        wr(`BIO_OFS_MEMCTL, 8'hFF);
        rchk(`BIO_OFS_MEMCTL, memctl);
        $display("test bus done");
        mem_mode <= BIO_MM_INTERNAL;
        {ext_val, cap_sel} <= {24'h070000, 1'h0};
        {ccp_oe, ccp_o} <= {1'h1, 1'($urandom)};
        wr(`BIO_OFS_E_DIR, 8'h07);
        wr(`BIO_OFS_SPCTL, 8'h10);
        chk({pe_drv.oe[7], pe_drv.out[7]}, {1'h1, ccp_o});
        b = 8'($urandom);
        bio_host_model_inst.host_write(b);
        chk(ccp2_in, ccp_o);
        spctl |= 8'h80;
        rchk(`BIO_OFS_SPCTL, spctl);
        rchk(`BIO_OFS_STATUS, b);
        spctl &= 8'h7F;
        rchk(`BIO_OFS_SPCTL, spctl);
        repeat (2) bio_host_model_inst.host_write(8'($urandom));
        spctl |= 8'hA0;
        rchk(`BIO_OFS_SPCTL, spctl);
        wr(`BIO_OFS_SPCTL, 8'h10);
        rchk(`BIO_OFS_SPCTL, spctl);
        wr(`BIO_OFS_D_PIN, b ^ 8'h3C);
        rchk(`BIO_OFS_SPCTL, spctl);
        bio_host_model_inst.host_read(b);
        chk({24'h0, b}, {24'h0, lat[1]});
        spctl &= 8'hBF;
        rchk(`BIO_OFS_SPCTL, spctl);
        $display("test slave port done");
        tally_and_finish();
    end
endmodule
